// ---- cbmc_pkg.sv ----
// Purpose: shared constants and types for the boost mode controller
// Assumes: 125 MHz system clock
// Notes:   timing counts derive from a common tick base
package cbmc_pkg;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned TICK_US        = 1;
    localparam int unsigned TICK_CYC       = TICK_US * CLK_MHZ;
    localparam int unsigned PULSE_US       = 128;
    localparam int unsigned PULSE_TICKS    = PULSE_US / TICK_US;
    localparam int unsigned OVLD_MS        = 30;
    localparam int unsigned OVLD_TICKS     = OVLD_MS * 1000 / TICK_US;
    localparam int unsigned SAFETY_S       = 32;
    localparam int unsigned SAFETY_TICKS   = SAFETY_S * 1000000 / TICK_US;
    localparam int unsigned CNT_W          = 26;

    typedef enum logic [2:0] {
        CBMC_PWRDN  = 3'h0,
        CBMC_HIZ    = 3'h1,
        CBMC_CCFG   = 3'h2,
        CBMC_SHORT  = 3'h3,
        CBMC_PWMCHG = 3'h4,
        CBMC_BOOST  = 3'h5
    } cbmc_mode_e;

    typedef struct packed {
        logic vbus_uvlo;
        logic vbus_min;
        logic bat_short;
        logic bat_lowv;
        logic bat_ov;
        logic bat_min;
        logic bus_ov;
        logic bus_ovld;
        logic chg_fault;
        logic otg;
    } cbmc_sense_s;

    typedef struct packed {
        cbmc_sense_s      s1;
        cbmc_sense_s      s2;
        cbmc_mode_e       mode;
        logic             boost_sel;
        logic             kick;
        logic             fault;
        logic             ovld_lock;
        logic             tmr_lock;
        logic             mode32m;
        logic [CNT_W-1:0] safety_cnt;
        logic [CNT_W-1:0] coarse_cnt;
        logic [CNT_W-1:0] ovld_cnt;
        logic [7:0]       pulse_cnt;
        logic [6:0]       tick_cnt;
        logic             tick;
        logic             stat_low;
    } cbmc_state_s;
endpackage : cbmc_pkg

// ---- cbmc_ctrl.sv ----
// Purpose: boost mode safety timer, boost faults, hi-z and charge states
// Assumes: analog comparator flags arrive asynchronously as level inputs
// Notes:   select, kick and clear bits arrive as one-cycle write strobes from the serial engine
//
// Contract
// - boost start launches 32 s safety timer
// - kick write restarts timer, self-clears
// - timer expiry stops boost, pulses, flags
// - timer fault latched until reset/clear
// - bus overvoltage stops boost, clears select
// - resume only on select write or otg
// - overload fault after 30 ms continuous
// - overload fault blocks boost until clear
// - battery out of range stops boost
// - battery recovery needs select or otg
// - one 128 us low pulse per fault
// - hi-z request without otg gives hi-z
// - coarse timer runs in hi-z, low battery
// - coarse expiry enters 32-minute mode
// - 32-minute mode uvlo forces hi-z
// - charge configure on block or fault
// - short state for low battery
// - pwm charge for normal battery
// - boost without fault, hi-z overrides
`timescale 1ns/1ns
module cbmc_ctrl #(
    parameter int unsigned SAFETY_TICKS = cbmc_pkg::SAFETY_TICKS,
    parameter int unsigned OVLD_TICKS   = cbmc_pkg::OVLD_TICKS,
    parameter int unsigned PULSE_TICKS  = cbmc_pkg::PULSE_TICKS,
    parameter int unsigned TICK_CYC     = cbmc_pkg::TICK_CYC
) (
    input  wire logic                CLK,
    input  wire logic                SYS_RST,
    input  wire cbmc_pkg::cbmc_sense_s SENSE,
    input  wire logic                HIZ_REQ,
    input  wire logic                CHG_DIS,
    input  wire logic                BOOST_SEL_WR,
    input  wire logic                BOOST_SEL_VAL,
    input  wire logic                KICK_WR,
    input  wire logic                FAULT_CLR,
    output logic                     BOOST_SEL,
    output logic                     KICK,
    output logic                     FAULT,
    output logic                     MODE_32M,
    output cbmc_pkg::cbmc_mode_e     MODE,
    output logic                     BOOST_ON,
    output logic                     BUCK_ON,
    output logic                     SHORT_ON,
    output logic                     LINEAR_LIMIT,
    output logic                     SERIAL_ON,
    output logic                     STAT_O,
    output logic                     STAT_OE
);
    cbmc_pkg::cbmc_state_s st_r;
    cbmc_pkg::cbmc_state_s st_nxt;

    logic        hiz;
    logic        boosting;
    logic        boost_fault;
    logic        safety_exp;
    logic        ovld_exp;
    logic        bat_bad;
    logic        pwrdn;
    logic        por;
    cbmc_pkg::cbmc_sense_s s;

    assign s = st_r.s2;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = SENSE;
        st_nxt.s2    = st_r.s1;
        st_nxt.tick  = 1'b0;
        if (st_r.tick_cnt == 7'(TICK_CYC - 1)) begin
            st_nxt.tick_cnt = 7'h00;
            st_nxt.tick     = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 7'h01;
        end

        pwrdn = s.vbus_uvlo && s.bat_short && !st_r.mode32m;
        por   = (st_r.mode == cbmc_pkg::CBMC_PWRDN) && !pwrdn;

        hiz = (HIZ_REQ && !s.otg) || (st_r.mode32m && s.vbus_uvlo && !s.otg);
        if (st_r.mode32m && s.vbus_uvlo) begin
            hiz = 1'b1;
        end
        boosting = st_r.mode == cbmc_pkg::CBMC_BOOST;

        st_nxt.kick = 1'b0;
        if (KICK_WR) begin
            st_nxt.kick = 1'b1;
        end
        safety_exp = 1'b0;
        if (!boosting || st_r.kick) begin
            st_nxt.safety_cnt = '0;
        end else if (st_r.tick) begin
            if (st_r.safety_cnt == cbmc_pkg::CNT_W'(SAFETY_TICKS - 1)) begin
                safety_exp = 1'b1;
                st_nxt.safety_cnt = '0;
            end else begin
                st_nxt.safety_cnt = st_r.safety_cnt + 1'b1;
            end
        end

        ovld_exp = 1'b0;
        if (!(boosting && s.bus_ovld)) begin
            st_nxt.ovld_cnt = '0;
        end else if (st_r.tick) begin
            if (st_r.ovld_cnt == cbmc_pkg::CNT_W'(OVLD_TICKS)) begin
                ovld_exp = 1'b1;
                st_nxt.ovld_cnt = '0;
            end else begin
                st_nxt.ovld_cnt = st_r.ovld_cnt + 1'b1;
            end
        end

        bat_bad     = s.bat_ov || s.bat_min;
        boost_fault = boosting && (safety_exp || ovld_exp || s.bus_ov || bat_bad);

        if (BOOST_SEL_WR) begin
            st_nxt.boost_sel = BOOST_SEL_VAL;
        end
        if (boosting && (ovld_exp || s.bus_ov || bat_bad)) begin
            st_nxt.boost_sel = 1'b0;
        end
        if (FAULT_CLR) begin
            st_nxt.fault     = 1'b0;
            st_nxt.ovld_lock = 1'b0;
            st_nxt.tmr_lock  = 1'b0;
        end
        if (boost_fault) begin
            st_nxt.fault = 1'b1;
        end
        if (ovld_exp) begin
            st_nxt.ovld_lock = 1'b1;
        end
        if (boosting && safety_exp) begin
            st_nxt.tmr_lock = 1'b1;
        end

        if (boost_fault) begin
            st_nxt.pulse_cnt = 8'(PULSE_TICKS);
        end else if (st_r.tick && st_r.pulse_cnt != 8'h00) begin
            st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
        end
        st_nxt.stat_low = st_nxt.pulse_cnt != 8'h00;

        if (!(st_r.mode == cbmc_pkg::CBMC_HIZ && s.bat_lowv) || st_r.mode32m) begin
            st_nxt.coarse_cnt = '0;
        end else if (st_r.tick) begin
            if (st_r.coarse_cnt == cbmc_pkg::CNT_W'(SAFETY_TICKS - 1)) begin
                st_nxt.mode32m    = 1'b1;
                st_nxt.coarse_cnt = '0;
            end else begin
                st_nxt.coarse_cnt = st_r.coarse_cnt + 1'b1;
            end
        end

        if (pwrdn) begin
            st_nxt.mode = cbmc_pkg::CBMC_PWRDN;
        end else if (hiz) begin
            st_nxt.mode = cbmc_pkg::CBMC_HIZ;
        end else if ((st_nxt.boost_sel || s.otg) && !boost_fault && !st_r.ovld_lock
                     && !bat_bad && !s.bus_ov && !st_r.tmr_lock) begin
            st_nxt.mode = cbmc_pkg::CBMC_BOOST;
        end else if (st_nxt.boost_sel || s.otg || s.vbus_uvlo) begin
            st_nxt.mode = s.vbus_uvlo ? cbmc_pkg::CBMC_HIZ : cbmc_pkg::CBMC_CCFG;
        end else if (s.vbus_min || CHG_DIS || s.chg_fault) begin
            st_nxt.mode = cbmc_pkg::CBMC_CCFG;
        end else if (s.bat_short) begin
            st_nxt.mode = cbmc_pkg::CBMC_SHORT;
        end else begin
            st_nxt.mode = cbmc_pkg::CBMC_PWMCHG;
        end

        if (por) begin
            st_nxt            = '0;
            st_nxt.s1         = SENSE;
            st_nxt.s2         = st_r.s1;
            st_nxt.mode       = cbmc_pkg::CBMC_CCFG;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign BOOST_SEL    = st_r.boost_sel;
    assign KICK         = st_r.kick;
    assign FAULT        = st_r.fault;
    assign MODE_32M     = st_r.mode32m;
    assign MODE         = st_r.mode;
    assign BOOST_ON     = st_r.mode == cbmc_pkg::CBMC_BOOST;
    assign BUCK_ON      = st_r.mode == cbmc_pkg::CBMC_PWMCHG;
    assign SHORT_ON     = st_r.mode == cbmc_pkg::CBMC_SHORT;
    assign LINEAR_LIMIT = BOOST_ON && s.bus_ovld;
    assign SERIAL_ON    = st_r.mode != cbmc_pkg::CBMC_PWRDN;
    assign STAT_O       = 1'b0;
    assign STAT_OE      = st_r.stat_low;

    AST_KICK_CLR: assert property (@(posedge CLK) disable iff (SYS_RST)
        KICK |=> !KICK)
        else $error("kick bit not cleared");
    AST_FAULT_PULSE: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(FAULT) |-> STAT_OE)
        else $error("no stat pulse on fault");
    AST_FAULT_STOP: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(FAULT) |-> !BOOST_ON)
        else $error("boost still on after fault");
    AST_OVLD_BLOCK: assert property (@(posedge CLK) disable iff (SYS_RST)
        (st_r.ovld_lock && !$past(FAULT_CLR)) |-> !BOOST_ON)
        else $error("boost while overload locked");
    AST_HIZ: assert property (@(posedge CLK) disable iff (SYS_RST)
        (HIZ_REQ && !s.otg && !pwrdn && !por) |=> (MODE == cbmc_pkg::CBMC_HIZ))
        else $error("hi-z not entered");
    AST_BUCK: assert property (@(posedge CLK) disable iff (SYS_RST)
        !(BUCK_ON && (BOOST_ON || SHORT_ON)))
        else $error("buck overlaps other converter");
    AST_SEL_DROP: assert property (@(posedge CLK) disable iff (SYS_RST)
        (BOOST_ON && s.bus_ov && !BOOST_SEL_WR) |=> !BOOST_SEL)
        else $error("select not cleared on overvoltage");
    AST_M32: assert property (@(posedge CLK) disable iff (SYS_RST)
        (MODE_32M && !por) |=> MODE_32M)
        else $error("32-minute mode lost");
    AST_KICK_SET: assert property (@(posedge CLK) disable iff (SYS_RST)
        (KICK_WR && !por) |=> KICK)
        else $error("kick bit not set");
    AST_SAFETY_ZERO: assert property (@(posedge CLK) disable iff (SYS_RST)
        st_r.kick |=> (st_r.safety_cnt == '0))
        else $error("safety timer not restarted");
    AST_SAFETY_FAULT: assert property (@(posedge CLK) disable iff (SYS_RST)
        safety_exp |=> FAULT)
        else $error("no fault on timer expiry");
    AST_TMR_LOCK: assert property (@(posedge CLK) disable iff (SYS_RST)
        st_r.tmr_lock |-> !BOOST_ON)
        else $error("boost while timer fault locked");
    AST_FAULT_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
        (FAULT && !FAULT_CLR && !por) |=> FAULT)
        else $error("fault lost without clear");
    AST_OV_STOP: assert property (@(posedge CLK) disable iff (SYS_RST)
        (BOOST_ON && s.bus_ov) |=> !BOOST_ON)
        else $error("boost on during overvoltage");
    AST_OV_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!BOOST_ON && s.bus_ov) |=> !BOOST_ON)
        else $error("boost started during overvoltage");
    AST_BOOST_REQ: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(BOOST_ON) |-> (BOOST_SEL || $past(s.otg)))
        else $error("boost without select or otg");
    AST_BAT_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!BOOST_ON && bat_bad) |=> !BOOST_ON)
        else $error("boost started with bad battery");
    AST_OVLD_WAIT: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!st_r.ovld_lock && st_r.ovld_cnt == '0) |=> !st_r.ovld_lock)
        else $error("overload fault too early");
    AST_OVLD_SEL: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(st_r.ovld_lock) |-> (!BOOST_SEL && FAULT))
        else $error("select or fault wrong on overload");
    AST_BAT_STOP: assert property (@(posedge CLK) disable iff (SYS_RST)
        (BOOST_ON && bat_bad) |=> (!BOOST_ON && !BOOST_SEL))
        else $error("boost on with bad battery");
    AST_STAT_QUIET: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!st_r.stat_low && !boost_fault) |=> !STAT_OE)
        else $error("stat pulse without fault");
    AST_COARSE_IDLE: assert property (@(posedge CLK) disable iff (SYS_RST)
        (MODE != cbmc_pkg::CBMC_HIZ) |=> (st_r.coarse_cnt == '0))
        else $error("coarse timer runs outside hi-z");
    AST_M32_HIZ: assert property (@(posedge CLK) disable iff (SYS_RST)
        (MODE_32M && s.vbus_uvlo && !por) |=> (MODE == cbmc_pkg::CBMC_HIZ))
        else $error("no hi-z on uvlo in 32-minute mode");
    AST_CCFG_DIS: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CHG_DIS && !HIZ_REQ && !s.vbus_uvlo && !s.otg && !BOOST_SEL && !BOOST_SEL_WR
         && !MODE_32M && !por) |=> (MODE == cbmc_pkg::CBMC_CCFG))
        else $error("charge configure not entered");
    AST_SHORT: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!CHG_DIS && !HIZ_REQ && !s.vbus_uvlo && !s.vbus_min && !s.chg_fault && !s.otg && s.bat_short
         && !BOOST_SEL && !BOOST_SEL_WR && !MODE_32M && !por) |=> SHORT_ON)
        else $error("short state not entered");
    AST_PWM: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!CHG_DIS && !HIZ_REQ && !s.vbus_uvlo && !s.vbus_min && !s.chg_fault && !s.otg && !s.bat_short
         && !BOOST_SEL && !BOOST_SEL_WR && !MODE_32M && !por) |=> BUCK_ON)
        else $error("pwm charge not entered");
    AST_TIMER_CCFG: assert property (@(posedge CLK) disable iff (SYS_RST)
        (safety_exp && BOOST_SEL && !BOOST_SEL_WR && !HIZ_REQ && !MODE_32M && !s.vbus_uvlo)
        |=> (MODE == cbmc_pkg::CBMC_CCFG))
        else $error("fault did not configure");
    AST_PWRDN: assert property (@(posedge CLK) disable iff (SYS_RST)
        pwrdn |=> (MODE == cbmc_pkg::CBMC_PWRDN))
        else $error("power down not entered");
    AST_POR_CLEAR: assert property (@(posedge CLK) disable iff (SYS_RST)
        por |=> (!FAULT && !BOOST_SEL && MODE == cbmc_pkg::CBMC_CCFG))
        else $error("state kept over power-on reset");
    AST_TICK: assert property (@(posedge CLK) disable iff (SYS_RST)
        st_r.tick |=> !st_r.tick)
        else $error("tick longer than one cycle");
endmodule : cbmc_ctrl

// ---- cbmc_host_model.sv ----
// Purpose: host model writing the control bits
// Assumes: select, kick and clear writes are one-cycle strobes
// Notes:   signals change on the falling edge
`timescale 1ns/1ns
module cbmc_host_model (
    input  wire logic clk,
    output logic      hiz_req,
    output logic      chg_dis,
    output logic      sel_wr,
    output logic      sel_val,
    output logic      kick_wr,
    output logic      fault_clr
);
    initial begin
        {hiz_req, chg_dis, sel_wr, sel_val, kick_wr, fault_clr} = 6'h00;
    end
    // 0 select write, 1 kick, 2 fault clear
    task automatic pulse(input int sel, input logic val);
        @(negedge clk);
        sel_val = val;
        sel_wr = (sel == 0);
        kick_wr = (sel == 1);
        fault_clr = (sel == 2);
        @(negedge clk);
        {sel_wr, kick_wr, fault_clr} = 3'h0;
    endtask : pulse
    task automatic cfg(input logic hz, input logic dis);
        @(negedge clk);
        hiz_req = hz;
        chg_dis = dis;
    endtask : cfg
endmodule : cbmc_host_model

// ---- test_charger_boost_mode_controller.sv ----
// Purpose: self-checking bench for the boost mode controller
// Assumes: shortened timer parameters
// Notes:   inputs change on the falling edge
`timescale 1ns/1ns
module test_charger_boost_mode_controller;
    localparam int unsigned PT = 4;
    localparam int unsigned TC = 2;
    logic clk, sys_rst, hiz_req, chg_dis, sel_wr, sel_val, kick_wr, fault_clr;
    logic boost_sel, kick, fault, mode_32m, boost_on, buck_on, short_on;
    logic lin_lim, serial_on, stat_o, stat_oe;
    cbmc_pkg::cbmc_sense_s sense;
    cbmc_pkg::cbmc_mode_e  mode;
    int err_total, compares;
    int fb[4] = '{3, 5, 4, 2};
    cbmc_host_model h (.clk(clk), .hiz_req(hiz_req), .chg_dis(chg_dis), .sel_wr(sel_wr),
        .sel_val(sel_val), .kick_wr(kick_wr), .fault_clr(fault_clr));
    cbmc_ctrl #(.SAFETY_TICKS(20), .OVLD_TICKS(5), .PULSE_TICKS(PT), .TICK_CYC(TC)) i_dut (
        .CLK(clk), .SYS_RST(sys_rst), .SENSE(sense), .HIZ_REQ(hiz_req), .CHG_DIS(chg_dis),
        .BOOST_SEL_WR(sel_wr), .BOOST_SEL_VAL(sel_val), .KICK_WR(kick_wr), .FAULT_CLR(fault_clr),
        .BOOST_SEL(boost_sel), .KICK(kick), .FAULT(fault), .MODE_32M(mode_32m), .MODE(mode),
        .BOOST_ON(boost_on), .BUCK_ON(buck_on), .SHORT_ON(short_on), .LINEAR_LIMIT(lin_lim),
        .SERIAL_ON(serial_on), .STAT_O(stat_o), .STAT_OE(stat_oe));
    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1
    task automatic chkm(input logic [2:0] got, input logic [2:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkm
    task automatic wmode(input cbmc_pkg::cbmc_mode_e m, input int n);
        for (int i = 0; i < n && mode !== m; i++) @(negedge clk);
        chkm(mode, m);
    endtask : wmode
    task automatic fault_seen;
        int n;
        n = 0;
        for (int i = 0; i < 200 && stat_oe !== 1'b1; i++) @(negedge clk);
        chk1(boost_on, 1'b0);
        chk1(fault, 1'b1);
        while (stat_oe === 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk1(n >= PT * TC - TC && n <= PT * TC + TC, 1'b1);
        chk1(stat_o, 1'b0);
    endtask : fault_seen
    task automatic results;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        results();
    end
    initial begin
        sys_rst = 1'b1;
        sense = 10'h280;
        repeat (16) @(negedge clk);
        chkm(mode, cbmc_pkg::CBMC_PWRDN);
        chk1(serial_on, 1'b0);
        sys_rst = 1'b0;
        sense = 10'h000;
        wmode(cbmc_pkg::CBMC_PWMCHG, 20);
        chk1(buck_on, 1'b1);
        chk1(serial_on, 1'b1);
        sense.bat_short = 1'b1;
        wmode(cbmc_pkg::CBMC_SHORT, 10);
        chk1(short_on, 1'b1);
        chk1(buck_on, 1'b0);
        sense.bat_short = 1'b0;
        h.cfg(1'b0, 1'b1);
        wmode(cbmc_pkg::CBMC_CCFG, 10);
        chk1(buck_on, 1'b0);
        h.cfg(1'b0, 1'b0);
        wmode(cbmc_pkg::CBMC_PWMCHG, 10);
        $display("test charge states done");
        h.pulse(0, 1'b1);
        wmode(cbmc_pkg::CBMC_BOOST, 10);
        h.pulse(1, 1'b1);
        chk1(kick, 1'b1);
        @(negedge clk);
        chk1(kick, 1'b0);
        repeat (4) begin
            repeat (20) @(negedge clk);
            h.pulse(1, 1'b1);
        end
        chkm(mode, cbmc_pkg::CBMC_BOOST);
        fault_seen();
        repeat (30) @(negedge clk);
        chk1(fault, 1'b1);
        h.pulse(0, 1'b0);
        h.pulse(2, 1'b0);
        chk1(fault, 1'b0);
        wmode(cbmc_pkg::CBMC_PWMCHG, 10);
        $display("test safety timer done");
        foreach (fb[k]) begin
            h.pulse(0, 1'b1);
            wmode(cbmc_pkg::CBMC_BOOST, 10);
            sense[fb[k]] = 1'b1;
            if (fb[k] == 2) begin
                repeat (6) @(negedge clk);
                chk1(lin_lim, 1'b1);
                chk1(fault, 1'b0);
            end
            fault_seen();
            chk1(boost_sel, 1'b0);
            sense[fb[k]] = 1'b0;
            h.pulse(0, 1'b1);
            repeat (6) @(negedge clk);
            chkm(mode, (fb[k] == 2) ? cbmc_pkg::CBMC_CCFG : cbmc_pkg::CBMC_BOOST);
            h.pulse(0, 1'b0);
            h.pulse(2, 1'b0);
            sense.otg = 1'b1;
            wmode(cbmc_pkg::CBMC_BOOST, 10);
            sense.otg = 1'b0;
            wmode(cbmc_pkg::CBMC_PWMCHG, 10);
        end
        $display("test boost faults done");
        h.cfg(1'b1, 1'b0);
        wmode(cbmc_pkg::CBMC_HIZ, 10);
        sense.bat_lowv = 1'b1;
        for (int i = 0; i < 300 && mode_32m !== 1'b1; i++) @(negedge clk);
        chk1(mode_32m, 1'b1);
        sense = 10'h200;
        h.cfg(1'b0, 1'b0);
        repeat (8) @(negedge clk);
        chkm(mode, cbmc_pkg::CBMC_HIZ);
        $display("test high impedance done");
        results();
    end
endmodule : test_charger_boost_mode_controller
